// File: sync_line_pkg.sv
package sync_line_pkg;

   // ==========================================================
   // Parameter word layout
   localparam int PB_MODE = 13;
   localparam int PB_PAR_EN = 11;
   localparam int PB_PAR_ODD = 10;
   localparam int PB_LEN_HI = 9;
   localparam int PB_LEN_LO = 8;
   localparam int PB_FILL_HI = 7;
   localparam logic [3:0] MIN_CHAR_LEN = 4'h5;

   // ==========================================================
   // Maintenance select codes
   localparam logic [1:0] MAINT_NORMAL = 2'h0;
   localparam logic [1:0] MAINT_INT_LOOP = 2'h1;
   localparam logic [1:0] MAINT_EXT_LOOP = 2'h2;

   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int DR_DELAY_NS = 200;
   localparam int DR_DELAY_CYC = (DR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ==========================================================
   // Types
   typedef struct packed {
      logic sync_mode;
      logic par_en;
      logic par_odd;
      logic [1:0] len_code;
      logic [7:0] fill;
   } line_cfg_s;

   typedef struct packed {
      line_cfg_s cfg;
      logic go;
      logic brk;
      logic [1:0] maint;
   } link_ctl_s;

   typedef struct packed {
      logic [7:0] data;
      logic framing_err;
      logic parity_err;
      logic match;
   } rx_result_s;

   typedef enum logic [1:0] {
      RX_IDLE = 2'b00,
      RX_DATA = 2'b01,
      RX_PAR = 2'b10,
      RX_STOP = 2'b11
   } rx_state_e;

   typedef enum logic [2:0] {
      TX_IDLE = 3'b000,
      TX_START = 3'b001,
      TX_DATA = 3'b010,
      TX_PAR = 3'b011,
      TX_STOP = 3'b100
   } tx_state_e;

endpackage : sync_line_pkg

// File: sync_isoch_serial_line.sv
// Behaviour
// - Strip clean sync match without flagging program
// - Bad stop: error now, ready 200 ns later
// - Bad-parity sync: error now, match+ready later
// - Buffer read clears ready, errors; done after
// - Receiver idles until next start bit
// - Accept chars, raise done, shift out serially
// - Clear forces idle: mark, done, end-of-char
// - Load copies control bits and fill character
// - Mode bit: clear isochronous, set synchronous
// - Transmit-go cleared inhibits transmitter
// - Line break disables serial data output
// - Drive line only in normal or external loop
// - Interrupt enables gate done and no-data flags
// - Start edge, then low sample starts framing
// - Synchronous underrun sends fill character
// - Isochronous frames start/stop, pauses, no fill

// ==========================================================
// Transmit character FIFO
module char_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic flush,
   // Fill side
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   // Drain side
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);

   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : bad_depth
      $error("char_fifo depth must be a power of two, at least 2");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_reg;
   logic [AW-1:0] rd_reg;
   logic [AW:0] count_reg;
   logic [AW:0] count_next;
   logic room_reg;
   logic empty_reg;
   wire push = in_valid && room_reg;
   wire pop = out_ready && !empty_reg;

   // Occupancy after this cycle's push and pop
   assign count_next = count_reg + (AW + 1)'(push) - (AW + 1)'(pop);
   assign in_ready = room_reg;
   assign out_valid = !empty_reg;
   assign out_data = mem[rd_reg];

   // Storage has no reset; pointers guard it
   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem[wr_reg] <= in_data;
      end
   end

   // Pointers and registered full/empty
   always_ff @(posedge clk)
   begin
      if (flush)
      begin
         wr_reg <= '0;
         rd_reg <= '0;
         count_reg <= '0;
         room_reg <= 1'b1;
         empty_reg <= 1'b1;
      end
      else
      begin
         wr_reg <= wr_reg + AW'(push);
         rd_reg <= rd_reg + AW'(pop);
         count_reg <= count_next;
         room_reg <= (count_next != (AW + 1)'(DEPTH));
         empty_reg <= (count_next == '0);
      end
   end
endmodule : char_fifo

// ==========================================================
// Top: serial line block
module sync_isoch_serial_line
   import sync_line_pkg::*;
#(
   parameter int FIFO_DEPTH = 8
) (
   // System clock and reset
   input wire logic core_clk,
   input wire logic srst,
   input wire logic clear_input,
   // Line parameter and transmit control
   input wire logic [15:0] param_word,
   input wire logic param_load,
   input wire logic tx_go,
   input wire logic line_break,
   input wire logic [1:0] maint_sel,
   input wire logic tx_complete_irq_enable,
   input wire logic no_data_irq_enable,
   input wire logic no_data_ack,
   // Transmit character stream
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic tx_ready,
   // Receive buffer and flags
   input wire logic rx_buffer_read_select,
   output logic [7:0] rx_buffer,
   output logic rx_char_ready_flag,
   output logic char_match_flag,
   output logic framing_error_out,
   output logic parity_error_out,
   output logic rx_error_out,
   output logic rx_done_flag,
   // Transmit flags and interrupt requests
   output logic tx_done_flag,
   output logic eoc_flag,
   output logic tx_no_data_flag,
   output logic tx_irq,
   output logic rx_irq,
   // Modem link
   input wire logic line_clk,
   input wire logic line_rx_input,
   output logic line_tx_output,
   output logic line_tx_enable
);

   // ==========================================================
   // Core domain: configuration
   line_cfg_s cfg_reg;
   link_ctl_s ctl_core;
   logic clr_hold_reg;
   logic [1:0] clr_back_reg;
   wire tx_clr = srst || clear_input || clr_hold_reg;

   // Load control bits and fill character
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         cfg_reg <= '0;
      end
      else if (param_load)
      begin
         cfg_reg <= {param_word[PB_MODE], param_word[PB_PAR_EN], param_word[PB_PAR_ODD],
                     param_word[PB_LEN_HI:PB_LEN_LO], param_word[PB_FILL_HI:0]};
      end
   end

   assign ctl_core = '{cfg: cfg_reg, go: tx_go, brk: line_break, maint: maint_sel};

   // ==========================================================
   // Core domain: transmit FIFO and word handshake
   logic fifo_out_valid;
   logic [7:0] fifo_out_data;
   logic [7:0] hold_reg;
   logic req_reg;
   logic ack_reg;
   logic ack_meta_reg;
   logic ack_sync_reg;
   logic fifo_in_ready;
   wire pending = req_reg != ack_sync_reg;
   wire take = fifo_out_valid && !pending;

   char_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) tx_fifo (
      .clk(core_clk),
      .flush(tx_clr),
      .in_valid(tx_valid),
      .in_data(tx_data),
      .in_ready(fifo_in_ready),
      .out_valid(fifo_out_valid),
      .out_data(fifo_out_data),
      .out_ready(!pending)
   );

   assign tx_ready = fifo_in_ready;

   // Hold word stable until the link acknowledges it
   always_ff @(posedge core_clk)
   begin
      if (tx_clr)
      begin
         hold_reg <= '0;
         req_reg <= 1'b0;
         ack_meta_reg <= 1'b0;
         ack_sync_reg <= 1'b0;
      end
      else
      begin
         ack_meta_reg <= ack_reg;
         ack_sync_reg <= ack_meta_reg;
         if (take)
         begin
            hold_reg <= fifo_out_data;
            req_reg <= !req_reg;
         end
      end
   end

   // ==========================================================
   // Link domain: resets and control crossing
   // Control is quasi-static; change it only while transmission is stopped
   logic [1:0] lrst_meta_reg;
   logic [1:0] lrst_reg;
   link_ctl_s ctl_meta_reg;
   link_ctl_s ctl_reg;
   logic req_meta_reg;
   logic req_sync_reg;

   always_ff @(posedge line_clk)
   begin
      lrst_meta_reg <= {srst, tx_clr};
      lrst_reg <= lrst_meta_reg;
      ctl_meta_reg <= ctl_core;
      ctl_reg <= ctl_meta_reg;
      req_meta_reg <= req_reg;
      req_sync_reg <= req_meta_reg;
   end

   wire link_rst = lrst_reg[1];
   wire link_tx_rst = lrst_reg[0];

   // Hold clear until the link has seen it
   always_ff @(posedge core_clk)
   begin
      clr_hold_reg <= srst || clear_input || (clr_hold_reg && !clr_back_reg[1]);
      clr_back_reg <= {clr_back_reg[0], link_tx_rst};
   end
   wire [3:0] char_len = MIN_CHAR_LEN + {2'h0, ctl_reg.cfg.len_code};
   wire [7:0] len_mask = 8'hff >> (4'h8 - char_len);
   wire [7:0] fill_masked = ctl_reg.cfg.fill & len_mask;

   // ==========================================================
   // Link domain: receiver
   rx_state_e rx_state_reg;
   logic [1:0] rx_pin_reg;
   logic rx_prev_reg;
   logic [7:0] rx_shift_reg;
   logic [3:0] rx_cnt_reg;
   logic rx_par_reg;
   rx_result_s rx_res_reg;
   logic rx_tog_reg;
   logic tx_line_reg;
   wire rx_bit = rx_pin_reg[1];
   wire [7:0] rx_char = rx_shift_reg >> (4'h8 - char_len);
   wire rx_par_bad = ctl_reg.cfg.par_en && ((^rx_char ^ rx_par_reg) != ctl_reg.cfg.par_odd);

   // Serial input passes two flops; internal loop takes own output
   always_ff @(posedge line_clk)
   begin
      rx_pin_reg <= {rx_pin_reg[0], (ctl_reg.maint == MAINT_INT_LOOP) ? tx_line_reg : line_rx_input};
   end

   // Framing one bit per link clock edge
   always_ff @(posedge line_clk)
   begin
      if (link_rst)
      begin
         rx_state_reg <= RX_IDLE;
         rx_prev_reg <= 1'b1;
         rx_shift_reg <= '0;
         rx_cnt_reg <= '0;
         rx_par_reg <= 1'b0;
         rx_res_reg <= '0;
         rx_tog_reg <= 1'b0;
      end
      else
      begin
         rx_prev_reg <= rx_bit;
         case (rx_state_reg)
            RX_IDLE:
            begin
               if (rx_prev_reg && !rx_bit)
               begin
                  rx_state_reg <= RX_DATA;
                  rx_cnt_reg <= '0;
               end
            end
            RX_DATA:
            begin
               rx_shift_reg <= {rx_bit, rx_shift_reg[7:1]};
               rx_cnt_reg <= rx_cnt_reg + 4'h1;
               if (rx_cnt_reg == char_len - 4'h1)
               begin
                  rx_state_reg <= ctl_reg.cfg.par_en ? RX_PAR : RX_STOP;
               end
            end
            RX_PAR:
            begin
               rx_par_reg <= rx_bit;
               rx_state_reg <= RX_STOP;
            end
            default:
            begin
               rx_res_reg <= '{data: rx_char, framing_err: !rx_bit, parity_err: rx_par_bad,
                               match: rx_char == fill_masked};
               rx_tog_reg <= !rx_tog_reg;
               rx_state_reg <= RX_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // Link domain: transmitter
   tx_state_e tx_state_reg;
   logic [7:0] tx_shift_reg;
   logic [3:0] tx_cnt_reg;
   logic tx_par_reg;
   logic tx_started_reg;
   logic tx_eoc_reg;
   logic nd_tog_reg;
   logic line_out_reg;
   logic line_en_reg;
   wire sync_md = ctl_reg.cfg.sync_mode;
   wire word_avail = req_sync_reg != ack_reg;
   wire data_done = tx_cnt_reg == char_len;
   wire char_end = (tx_state_reg == TX_IDLE) || (tx_state_reg == TX_STOP)
                || (sync_md && tx_state_reg == TX_PAR)
                || (sync_md && tx_state_reg == TX_DATA && data_done && !ctl_reg.cfg.par_en);
   wire use_fill = !word_avail && sync_md && tx_started_reg;
   wire tx_load = ctl_reg.go && (word_avail || use_fill);
   wire [7:0] tx_word = (word_avail ? hold_reg : ctl_reg.cfg.fill) & len_mask;

   // Character sequencing at character boundaries
   always_ff @(posedge line_clk)
   begin
      if (link_tx_rst)
      begin
         tx_state_reg <= TX_IDLE;
         tx_line_reg <= 1'b1;
         tx_shift_reg <= '0;
         tx_cnt_reg <= '0;
         tx_par_reg <= 1'b0;
         tx_started_reg <= 1'b0;
         tx_eoc_reg <= 1'b1;
         ack_reg <= 1'b0;
         nd_tog_reg <= 1'b0;
      end
      else if (char_end && tx_load)
      begin
         ack_reg <= word_avail ? req_sync_reg : ack_reg;
         nd_tog_reg <= nd_tog_reg ^ use_fill;
         tx_par_reg <= ^tx_word ^ ctl_reg.cfg.par_odd;
         tx_started_reg <= 1'b1;
         if (sync_md)
         begin
            tx_line_reg <= tx_word[0];
            tx_shift_reg <= tx_word >> 1;
            tx_cnt_reg <= 4'h1;
            tx_state_reg <= TX_DATA;
            tx_eoc_reg <= 1'b0;
         end
         else
         begin
            tx_line_reg <= 1'b0;
            tx_shift_reg <= tx_word;
            tx_state_reg <= TX_START;
         end
      end
      else if (char_end)
      begin
         tx_state_reg <= TX_IDLE;
         tx_line_reg <= 1'b1;
         tx_eoc_reg <= 1'b1;
         tx_started_reg <= tx_started_reg && ctl_reg.go;
      end
      else
      begin
         case (tx_state_reg)
            TX_START:
            begin
               tx_line_reg <= tx_shift_reg[0];
               tx_shift_reg <= tx_shift_reg >> 1;
               tx_cnt_reg <= 4'h1;
               tx_state_reg <= TX_DATA;
               tx_eoc_reg <= 1'b0;
            end
            TX_DATA:
            begin
               if (data_done)
               begin
                  tx_line_reg <= ctl_reg.cfg.par_en ? tx_par_reg : 1'b1;
                  tx_state_reg <= ctl_reg.cfg.par_en ? TX_PAR : TX_STOP;
                  tx_eoc_reg <= 1'b1;
               end
               else
               begin
                  tx_line_reg <= tx_shift_reg[0];
                  tx_shift_reg <= tx_shift_reg >> 1;
                  tx_cnt_reg <= tx_cnt_reg + 4'h1;
               end
            end
            default:
            begin
               tx_line_reg <= 1'b1;
               tx_state_reg <= TX_STOP;
            end
         endcase
      end
   end

   // Line pins: break forces space, maintenance gates the driver
   always_ff @(posedge line_clk)
   begin
      if (link_tx_rst)
      begin
         line_out_reg <= 1'b1;
         line_en_reg <= 1'b0;
      end
      else
      begin
         line_out_reg <= tx_line_reg && !ctl_reg.brk;
         line_en_reg <= (ctl_reg.maint == MAINT_NORMAL) || (ctl_reg.maint == MAINT_EXT_LOOP);
      end
   end

   assign line_tx_output = line_out_reg;
   assign line_tx_enable = line_en_reg;

   // ==========================================================
   // Core domain: event crossings back from the link
   logic [2:0] rx_tog_sync_reg;
   logic [2:0] nd_tog_sync_reg;
   logic [1:0] eoc_sync_reg;

   always_ff @(posedge core_clk)
   begin
      rx_tog_sync_reg <= {rx_tog_sync_reg[1:0], rx_tog_reg};
      nd_tog_sync_reg <= {nd_tog_sync_reg[1:0], nd_tog_reg};
      eoc_sync_reg <= {eoc_sync_reg[0], tx_eoc_reg};
   end

   wire rx_event = rx_tog_sync_reg[2] != rx_tog_sync_reg[1];
   wire nd_event = nd_tog_sync_reg[2] != nd_tog_sync_reg[1];

   // ==========================================================
   // Core domain: receive flags
   logic [7:0] rxbuf_reg;
   logic fe_reg;
   logic pe_reg;
   logic err_reg;
   logic ready_reg;
   logic match_reg;
   logic done_reg;
   logic sel_prev_reg;
   logic pend_match_reg;
   logic [$clog2(DR_DELAY_CYC + 1)-1:0] dly_reg;
   wire rx_clean = !rx_res_reg.framing_err && !rx_res_reg.parity_err;
   wire strip = rx_res_reg.match && rx_clean;
   wire dly_fire = dly_reg == 1;
   wire sel_end = sel_prev_reg && !rx_buffer_read_select;

   // Error now, ready after the counted delay; set wins over read clear
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         rxbuf_reg <= '0;
         fe_reg <= 1'b0;
         pe_reg <= 1'b0;
         err_reg <= 1'b0;
         ready_reg <= 1'b0;
         match_reg <= 1'b0;
         done_reg <= 1'b0;
         sel_prev_reg <= 1'b0;
         pend_match_reg <= 1'b0;
         dly_reg <= '0;
      end
      else
      begin
         sel_prev_reg <= rx_buffer_read_select;
         if (rx_event)
         begin
            rxbuf_reg <= rx_res_reg.data;
            pend_match_reg <= rx_res_reg.match;
            dly_reg <= strip ? '0 : ($bits(dly_reg))'(DR_DELAY_CYC);
         end
         else if (dly_reg != 0)
         begin
            dly_reg <= dly_reg - 1'b1;
         end
         fe_reg <= (rx_event && rx_res_reg.framing_err) || (fe_reg && !rx_buffer_read_select);
         pe_reg <= (rx_event && rx_res_reg.parity_err) || (pe_reg && !rx_buffer_read_select);
         err_reg <= (rx_event && !rx_clean) || (err_reg && !rx_buffer_read_select);
         ready_reg <= dly_fire || (ready_reg && !rx_buffer_read_select);
         match_reg <= dly_fire ? pend_match_reg : (match_reg && !rx_buffer_read_select);
         done_reg <= dly_fire || (done_reg && !sel_end);
      end
   end

   assign rx_buffer = rxbuf_reg;
   assign rx_char_ready_flag = ready_reg;
   assign char_match_flag = match_reg;
   assign framing_error_out = fe_reg;
   assign parity_error_out = pe_reg;
   assign rx_error_out = err_reg;
   assign rx_done_flag = done_reg;

   // ==========================================================
   // Core domain: transmit flags and interrupt requests
   logic nd_reg;
   logic tx_done_reg;
   logic eoc_reg;
   logic tx_irq_reg;
   logic rx_irq_reg;

   always_ff @(posedge core_clk)
   begin
      if (tx_clr)
      begin
         nd_reg <= 1'b0;
         tx_done_reg <= 1'b1;
         eoc_reg <= 1'b1;
         tx_irq_reg <= 1'b0;
         rx_irq_reg <= 1'b0;
      end
      else
      begin
         nd_reg <= nd_event || (nd_reg && !no_data_ack);
         tx_done_reg <= fifo_in_ready;
         eoc_reg <= eoc_sync_reg[1];
         tx_irq_reg <= (tx_done_reg && tx_complete_irq_enable) || (nd_reg && no_data_irq_enable);
         rx_irq_reg <= done_reg;
      end
   end

   assign tx_no_data_flag = nd_reg;
   assign tx_done_flag = tx_done_reg;
   assign eoc_flag = eoc_reg;
   assign tx_irq = tx_irq_reg;
   assign rx_irq = rx_irq_reg;

endmodule : sync_isoch_serial_line

// File: sync_line_props.sv
// =====
// Port checker for the serial line block
module sync_line_props (
   // Clocks and reset
   input wire logic core_clk,
   input wire logic srst,
   input wire logic line_clk,
   // Controls
   input wire logic clear_input,
   input wire logic line_break,
   input wire logic [1:0] maint_sel,
   input wire logic tx_complete_irq_enable,
   input wire logic no_data_irq_enable,
   input wire logic rx_buffer_read_select,
   // Flags and line
   input wire logic tx_ready,
   input wire logic rx_char_ready_flag,
   input wire logic char_match_flag,
   input wire logic framing_error_out,
   input wire logic parity_error_out,
   input wire logic rx_error_out,
   input wire logic rx_done_flag,
   input wire logic tx_done_flag,
   input wire logic tx_no_data_flag,
   input wire logic tx_irq,
   input wire logic rx_irq,
   input wire logic line_tx_output,
   input wire logic line_tx_enable
);
   // Most checks live in the core domain
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);

   // =====
   // Receive side
   property p_err_ready;
      $rose(rx_error_out) |-> !rx_char_ready_flag ##[18:22] rx_char_ready_flag;
   endproperty
   property p_match_err;
      $rose(char_match_flag) |-> rx_error_out;
   endproperty
   property p_read_clear;
      rx_buffer_read_select ##1 rx_buffer_read_select |-> !(rx_char_ready_flag | char_match_flag | rx_error_out);
   endproperty
   property p_done_clear;
      $fell(rx_buffer_read_select) |-> ##[0:1] !rx_done_flag;
   endproperty
   property p_rx_irq;
      $rose(rx_done_flag) |=> rx_irq;
   endproperty
   a_err_ready: assert property (p_err_ready) else $error("ready not 200 ns after error");
   a_match_err: assert property (p_match_err) else $error("clean match was flagged");
   a_read_clear: assert property (p_read_clear) else $error("read left flags set");
   a_done_clear: assert property (p_done_clear) else $error("done stayed after read");
   a_rx_irq: assert property (p_rx_irq) else $error("no receive request");

   // =====
   // Transmit side
   property p_clear_idle;
      clear_input |=> tx_done_flag && tx_ready;
   endproperty
   property p_irq_gate;
      !tx_complete_irq_enable && !no_data_irq_enable |=> !tx_irq;
   endproperty
   property p_irq_done;
      tx_complete_irq_enable && tx_done_flag |=> tx_irq;
   endproperty
   property p_break;
      @(posedge line_clk) disable iff (srst) line_break [*6] |-> !line_tx_output;
   endproperty
   property p_maint_off;
      @(posedge line_clk) disable iff (srst) (maint_sel == 2'h3) [*6] |-> !line_tx_enable;
   endproperty
   property p_maint_on;
      @(posedge line_clk) disable iff (srst) (maint_sel == 2'h2) [*6] |-> line_tx_enable;
   endproperty
   a_clear_idle: assert property (p_clear_idle) else $error("clear did not idle");
   a_irq_gate: assert property (p_irq_gate) else $error("request while disabled");
   a_irq_done: assert property (p_irq_done) else $error("done request missing");
   a_break: assert property (p_break) else $error("break did not space line");
   a_maint_off: assert property (p_maint_off) else $error("line driven in other mode");
   a_maint_on: assert property (p_maint_on) else $error("line idle in external loop");

   // Main scenarios reached
   c_frame: cover property ($rose(framing_error_out));
   c_match: cover property ($rose(char_match_flag));
   c_no_data: cover property ($rose(tx_no_data_flag));
   c_full: cover property (!tx_ready);
endmodule : sync_line_props

// File: line_modem.sv
// =====
// Modem: bit clock, serial source and sink
module line_modem (
   // Link lines
   output logic line_clk,
   output logic line_rx_input,
   input wire logic line_tx_output
);
   timeunit 1ns;
   timeprecision 1ps;

   // Free bit clock, as a synchronous modem never stops it
   initial
   begin
      line_clk = 1'b0;
      line_rx_input = 1'b1;
      #37;
      forever #80 line_clk = ~line_clk;
   end

   // One frame, first bit first, mark again after it
   task automatic send_frame(input logic [10:0] bits);
      for (int i = 0; i < 11; i++)
      begin
         @(negedge line_clk);
         line_rx_input = bits[i];
      end
      @(negedge line_clk);
      line_rx_input = 1'b1;
   endtask : send_frame

   // Sample mid-bit from the start edge on
   task automatic grab_frame(output logic [10:0] bits);
      while (line_tx_output !== 1'b0)
         @(negedge line_clk);
      for (int i = 0; i < 11; i++)
      begin
         bits[i] = line_tx_output;
         @(negedge line_clk);
      end
   endtask : grab_frame
endmodule : line_modem

// File: sync_isoch_serial_line_tb.sv
// =====
// Self-checking bench
module sync_isoch_serial_line_tb
   import sync_line_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic core_clk, srst, clear_input, param_load, tx_go, line_break, no_data_ack, tx_valid;
   logic tx_complete_irq_enable, no_data_irq_enable, rx_buffer_read_select;
   logic [15:0] param_word;
   logic [1:0] maint_sel;
   logic [7:0] tx_data, rx_buffer, d;
   logic tx_ready, rx_char_ready_flag, char_match_flag, framing_error_out, parity_error_out;
   logic rx_error_out, rx_done_flag, tx_done_flag, eoc_flag, tx_no_data_flag, tx_irq, rx_irq;
   logic line_clk, line_rx_input, line_tx_output, line_tx_enable, pb, sb;
   logic [10:0] fr;
   logic [31:0] seed_val;
   int mismatches, num_checks, n;
   line_cfg_s cfg;

   sync_isoch_serial_line #(.FIFO_DEPTH(8)) DUT (.*);
   line_modem modem (.*);

   // System clock
   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // Repeatable random source
   function automatic logic [7:0] rnd8();
      seed_val = {seed_val[30:0], seed_val[31] ^ seed_val[21] ^ seed_val[1] ^ seed_val[0]};
      return seed_val[7:0];
   endfunction : rnd8

   // Expected {ready, match, framing, parity, summary, done, request}
   function automatic logic [6:0] rx_expect(input logic [7:0] v, input logic p, input logic s);
      logic m, r;
      m = (v == cfg.fill);
      r = (p | s) | ~m;
      return {r, m & (p | s), s, p, p | s, r, r};
   endfunction : rx_expect

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      num_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("FAIL %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : final_report

   task automatic cyc(input int k);
      repeat (k) @(negedge core_clk);
   endtask : cyc

   // Clear first, then parameters and controls
   task automatic setup(input logic sync);
      cyc(1);
      clear_input = 1'b1;
      cyc(1);
      clear_input = 1'b0;
      cfg = '{sync, 1'b1, 1'b1, 2'h3, rnd8()};
      param_word = {2'h0, sync, 1'b0, cfg[11:0]};
      param_load = 1'b1;
      cyc(1);
      param_load = 1'b0;
      tx_go = 1'b1;
      cyc(80);
   endtask : setup

   task automatic push(input logic [7:0] v);
      cyc(1);
      tx_valid = 1'b1;
      tx_data = v;
      while (tx_ready !== 1'b1)
         cyc(1);
      cyc(1);
      tx_valid = 1'b0;
   endtask : push

   task automatic read_buf();
      cyc(1);
      rx_buffer_read_select = 1'b1;
      cyc(2);
      check({rx_char_ready_flag, char_match_flag, rx_error_out}, 3'h0, "read clear");
      rx_buffer_read_select = 1'b0;
      cyc(2);
      check(rx_done_flag, 1'b0, "done clear");
   endtask : read_buf

   // Hang guard, far beyond the expected run
   initial
   begin
      #800us;
      mismatches++;
      final_report();
   end

   // Main sequence
   initial
   begin
      seed_val = 32'hb38e;
      mismatches = 0;
      num_checks = 0;
      {srst, clear_input, param_load, tx_go, line_break, no_data_ack, tx_valid} = 7'h40;
      {tx_complete_irq_enable, no_data_irq_enable, rx_buffer_read_select} = 3'h0;
      param_word = 16'h0000;
      maint_sel = 2'h0;
      tx_data = 8'h00;
      repeat (4) @(negedge line_clk);
      cyc(1);
      srst = 1'b0;
      check({tx_done_flag, eoc_flag, line_tx_output, rx_char_ready_flag}, 4'he, "reset");
      setup(1'b0);
      // Receive clean, fill-match, bad-stop and bad-parity frames with random gaps
      for (int i = 0; i < 10; i++)
      begin
         d = (i % 5 == 1 || i % 5 == 3) ? cfg.fill : rnd8();
         pb = (i % 5 >= 3);
         sb = (i % 5 == 2);
         repeat (rnd8() % 8) @(negedge line_clk);
         modem.send_frame({~sb, (~^d) ^ pb, d, 1'b0});
         cyc(60);
         check({rx_char_ready_flag, char_match_flag, framing_error_out, parity_error_out, rx_error_out,
                rx_done_flag, rx_irq}, rx_expect(d, pb, sb), "rx flags");
         check(rx_buffer, d, "rx data");
         read_buf();
      end
      // Isochronous frames, done request enabled
      tx_complete_irq_enable = 1'b1;
      cyc(3);
      check(tx_irq, 1'b1, "done request");
      for (int i = 0; i < 3; i++)
      begin
         d = rnd8();
         push(d);
         modem.grab_frame(fr);
         check(fr, {1'b1, ~^d, d, 1'b0}, "tx frame");
      end
      tx_complete_irq_enable = 1'b0;
      cyc(400);
      check({tx_no_data_flag, tx_irq, line_tx_output}, 3'h1, "isoch pause");
      // Halted transmitter fills the buffer until refused
      tx_go = 1'b0;
      n = 0;
      cyc(1);
      tx_valid = 1'b1;
      repeat (12)
      begin
         tx_data = rnd8();
         n += tx_ready;
         cyc(1);
      end
      tx_valid = 1'b0;
      check(n inside {8, 9}, 1'b1, "depth");
      check({tx_ready, tx_done_flag}, 2'h0, "full");
      cyc(400);
      check(line_tx_output, 1'b1, "halted mark");
      setup(1'b0);
      check({tx_ready, tx_done_flag, eoc_flag, line_tx_output}, 4'hf, "cleared");
      line_break = 1'b1;
      cyc(160);
      check(line_tx_output, 1'b0, "break");
      line_break = 1'b0;
      for (int m = 3; m >= 0; m--)
      begin
         maint_sel = m[1:0];
         cyc(160);
         check(line_tx_enable, m == 0 || m == 2, "line drive");
      end
      // Synchronous underrun sends fill
      setup(1'b1);
      no_data_irq_enable = 1'b1;
      push(rnd8());
      cyc(600);
      check({tx_no_data_flag, tx_irq}, 2'h3, "no data");
      no_data_ack = 1'b1;
      cyc(1);
      no_data_ack = 1'b0;
      no_data_irq_enable = 1'b0;
      cyc(3);
      check(tx_irq, 1'b0, "masked");
      final_report();
   end
endmodule : sync_isoch_serial_line_tb

bind sync_isoch_serial_line sync_line_props props (.*);
